//--- design/lin_uart_rx_status_flags.sv
`timescale 1ns/100ps
`default_nettype none
`include "lin_uart_params.svh"
module lin_uart_rx_status_flags
  import lin_uart_pkg::*;
(
  // clock and reset
  input  wire logic        i_clk,
  input  wire logic        i_rst_n,
  // avalon-mm slave
  input  wire logic [2:0]  i_avs_address,
  input  wire logic        i_avs_read,
  input  wire logic        i_avs_write,
  input  wire logic [31:0] i_avs_writedata,
  output logic [31:0]      o_avs_readdata,
  output logic             o_avs_waitrequest,
  // serial line
  input  wire logic        i_rx_pin,
  // lin frame engine events
  input  wire logic        i_lin_frame_start,
  input  wire logic        i_lin_frame_done,
  input  wire logic        i_lin_unreq,
  input  wire logic        i_lin_bit_err,
  input  wire logic        i_lin_overflow,
  input  wire logic        i_lin_crc_err,
  input  wire logic        i_lin_cks_err,
  // transmitter
  input  wire logic        i_tx_taken,
  output logic [7:0]       o_lin_tx_data,
  // dma and interrupt
  output logic             o_dma_rx_req,
  output logic             o_dma_tx_req,
  output logic             o_irq
);

  // ----------------------------------------------------------------
  // reset release
  // ----------------------------------------------------------------
  logic [1:0] rst_sync_q;
  logic       rst_n;

  always_ff @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      rst_sync_q <= 2'h0;
    end
    else
    begin
      rst_sync_q <= {rst_sync_q[0], 1'b1};
    end
  end
  assign rst_n = rst_sync_q[1];

  // ----------------------------------------------------------------
  // receiver
  // ----------------------------------------------------------------
  top_regs_t  r_q;
  top_regs_t  r_d;
  logic       rx_done;
  logic [7:0] rx_data;
  logic       rx_perr;
  logic       rx_ferr;
  logic       rx_idle;
  logic       rx_line;

  lin_rx_sampler u_rx (
    .i_clk       (i_clk),
    .i_rst_n     (rst_n),
    .i_rx_pin    (i_rx_pin),
    .i_enable    (r_q.ctrl[`CTRL_RX_EN]),
    .i_parity_en (r_q.ctrl[`CTRL_PARITY_EN]),
    .i_divisor   (r_q.baud),
    .o_done      (rx_done),
    .o_data      (rx_data),
    .o_par_err   (rx_perr),
    .o_frame_err (rx_ferr),
    .o_idle      (rx_idle),
    .o_line      (rx_line)
  );

  // ----------------------------------------------------------------
  // register file and flag logic
  // ----------------------------------------------------------------
  logic              req;
  logic              fin;
  logic              wr_fin;
  logic              rd_fin;
  logic              dma_rx;
  logic              full;
  logic [`ST1_W-1:0] set1;
  logic [`ST1_W-1:0] clr1;
  logic [`ST2_W-1:0] lin_ev;
  logic [`ST2_W-1:0] clr2;
  logic [31:0]       st1_word;
  logic [31:0]       mux;

  always_comb
  begin
    r_d      = r_q;
    req      = i_avs_read | i_avs_write;
    // access completes on the edge where waitrequest is seen low
    fin      = req & r_q.ack;
    wr_fin   = fin & i_avs_write;
    rd_fin   = fin & i_avs_read;
    dma_rx   = r_q.ctrl[`CTRL_DMA_RX];
    full     = dma_rx ? r_q.dma_rx_req : r_q.st1[`ST1_RX_DATA_FULL_FLAG];
    lin_ev   = {i_lin_cks_err, i_lin_crc_err, i_lin_overflow,
                i_lin_bit_err, i_lin_unreq};
    set1     = '0;
    clr1     = '0;
    clr2     = '0;
    st1_word = '0;
    st1_word[`ST1_W-1:0]   = r_q.st1;
    st1_word[`ST1_LIN_ACT] = r_q.lin_act;
    st1_word[`ST1_WAKE_ACT] = r_q.wake_act;
    st1_word[`ST1_DMA_ACT] = r_q.dma_rx_req | r_q.dma_tx_req;

    // lin errors wait for the closing stop bit
    r_d.pend2 = r_q.pend2 | lin_ev;
    if (rx_done)
    begin
      r_d.rx_buf = rx_data;
      set1[`ST1_OVERRUN] = full;
      set1[`ST1_PARITY]  = rx_perr;
      set1[`ST1_RX_DATA_FULL_FLAG]    = ~dma_rx;
      set1[`ST1_LIN_RX_READY_FLAG]   = ~dma_rx;
      r_d.pend2 = lin_ev;
    end
    set1[`ST1_FRAME] = rx_ferr;
    set1[`ST1_IDLE]  = rx_idle;

    // bus side
    r_d.ack = req & ~r_q.ack;
    case (i_avs_address)
      `IDX_CTRL:       mux = {27'h0, r_q.ctrl};
      `IDX_STATUS_ONE: mux = st1_word;
      `IDX_STATUS_TWO: mux = {27'h0, r_q.st2};
      `IDX_MASK_ONE:   mux = {26'h0, r_q.msk1};
      `IDX_MASK_TWO:   mux = {27'h0, r_q.msk2};
      `IDX_LIN_TX:     mux = {24'h0, r_q.lin_tx};
      `IDX_RX_DATA:    mux = {24'h0, r_q.rx_buf};
      `IDX_BAUD:       mux = {16'h0, r_q.baud};
      default:         mux = 32'h0000_0000;
    endcase
    if (req & ~r_q.ack)
    begin
      r_d.rdata = i_avs_read ? mux : 32'h0000_0000;
    end
    if (rd_fin)
    begin
      case (i_avs_address)
        // clear only what the answer showed: a flag set in between survives
        `IDX_STATUS_ONE: clr1 = r_q.rdata[`ST1_W-1:0];
        `IDX_STATUS_TWO: clr2 = r_q.rdata[`ST2_W-1:0];
        `IDX_RX_DATA:
        begin
          clr1[`ST1_RX_DATA_FULL_FLAG]  = 1'b1;
          clr1[`ST1_LIN_RX_READY_FLAG] = 1'b1;
          r_d.dma_rx_req   = 1'b0;
        end
        default: ;
      endcase
    end
    if (wr_fin)
    begin
      case (i_avs_address)
        `IDX_CTRL:     r_d.ctrl = i_avs_writedata[`CTRL_W-1:0];
        `IDX_MASK_ONE: r_d.msk1 = i_avs_writedata[`ST1_W-1:0];
        `IDX_MASK_TWO: r_d.msk2 = i_avs_writedata[`ST2_W-1:0];
        `IDX_BAUD:     r_d.baud = i_avs_writedata[15:0];
        `IDX_LIN_TX:
        begin
          r_d.lin_tx   = i_avs_writedata[7:0];
          r_d.tx_empty = 1'b0;
        end
        default: ;
      endcase
    end

    // sticky flags: a new event beats the read-clear
    r_d.st1 = (r_q.st1 & ~clr1) | set1;
    r_d.st2 = (r_q.st2 & ~clr2) | (rx_done ? r_q.pend2 : '0);

    // dma request for the received byte
    if (rx_done & dma_rx)
    begin
      r_d.dma_rx_req = 1'b1;
    end
    if (i_tx_taken)
    begin
      r_d.tx_empty = 1'b1;
    end
    r_d.dma_tx_req = r_d.ctrl[`CTRL_DMA_TX] & r_d.tx_empty;

    if (i_lin_frame_done)
    begin
      r_d.lin_act = 1'b0;
    end
    if (i_lin_frame_start | (wr_fin & (i_avs_address == `IDX_LIN_TX)))
    begin
      r_d.lin_act = 1'b1;
    end
    r_d.wake_act = r_q.ctrl[`CTRL_SLEEP] & ~rx_line;

    r_d.irq = |(r_d.st1 & r_d.msk1) | |(r_d.st2 & r_d.msk2);
  end

  always_ff @(posedge i_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      r_q          <= '0;
      r_q.ctrl     <= `CTRL_RESET;
      r_q.baud     <= `BAUD_RESET;
      r_q.lin_tx   <= `LIN_TX_RESET;
      r_q.tx_empty <= 1'b1;
    end
    else
    begin
      r_q <= r_d;
    end
  end

  assign o_avs_readdata    = r_q.rdata;
  assign o_avs_waitrequest = ~r_q.ack;
  assign o_lin_tx_data     = r_q.lin_tx;
  assign o_dma_rx_req      = r_q.dma_rx_req;
  assign o_dma_tx_req      = r_q.dma_tx_req;
  assign o_irq             = r_q.irq;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (!rst_n);

  property p_rx_data_full_flag_not_in_dma;
    rx_done && dma_rx |=> !$rose(r_q.st1[`ST1_RX_DATA_FULL_FLAG]);
  endproperty
  a_rx_data_full_flag_not_in_dma: assert property (p_rx_data_full_flag_not_in_dma)
    else $error("data-full raised in dma receive mode");

  property p_lin_rx_ready_flag_timing;
    $rose(r_q.st1[`ST1_LIN_RX_READY_FLAG]) |-> $past(rx_done && !dma_rx);
  endproperty
  a_lin_rx_ready_flag_timing: assert property (p_lin_rx_ready_flag_timing)
    else $error("rx-ready raised without a verified stop bit");

  property p_overrun;
    rx_done && full |=> r_q.st1[`ST1_OVERRUN];
  endproperty
  a_overrun: assert property (p_overrun)
    else $error("overrun missed on full receive buffer");

  property p_lin_err_at_stop;
    $rose(r_q.st2[0]) |-> $past(rx_done);
  endproperty
  a_lin_err_at_stop: assert property (p_lin_err_at_stop)
    else $error("lin error flag raised away from stop sample");

  property p_dma_active;
    !o_avs_waitrequest && i_avs_read
      && (i_avs_address == `IDX_STATUS_ONE)
      && $past(o_dma_rx_req || o_dma_tx_req)
      |-> o_avs_readdata[`ST1_DMA_ACT];
  endproperty
  a_dma_active: assert property (p_dma_active)
    else $error("dma-active low with a pending request");

  property p_lin_tx_readback;
    wr_fin && i_avs_address == `IDX_LIN_TX
      |=> o_lin_tx_data == $past(i_avs_writedata[7:0]);
  endproperty
  a_lin_tx_readback: assert property (p_lin_tx_readback)
    else $error("lin transmit register lost its written value");

  property p_lin_active;
    i_lin_frame_start |=> r_q.lin_act;
  endproperty
  a_lin_active: assert property (p_lin_active)
    else $error("lin-active not set at frame start");

  property p_wake_active;
    r_q.ctrl[`CTRL_SLEEP] && !rx_line |=> r_q.wake_act;
  endproperty
  a_wake_active: assert property (p_wake_active)
    else $error("wakeup-active missing on dominant line");

  property p_answer;
    req && o_avs_waitrequest |-> ##[1:2] !o_avs_waitrequest;
  endproperty
  a_answer: assert property (p_answer)
    else $error("bus request not answered in time");

  c_dma_char: cover property (rx_done && dma_rx);
  c_irq: cover property ($rose(o_irq));

endmodule
`default_nettype wire

//--- design/lin_uart_params.svh
`ifndef LIN_UART_PARAMS_SVH
`define LIN_UART_PARAMS_SVH

// ----------------------------------------------------------------
// register word indices (byte address is four times the index)
// ----------------------------------------------------------------
`define IDX_CTRL          3'h0
`define IDX_STATUS_ONE    3'h1
`define IDX_STATUS_TWO    3'h2
`define IDX_MASK_ONE      3'h3
`define IDX_MASK_TWO      3'h4
`define IDX_LIN_TX        3'h5
`define IDX_RX_DATA       3'h6
`define IDX_BAUD          3'h7

// ----------------------------------------------------------------
// field positions and widths
// ----------------------------------------------------------------
`define CTRL_W            5
`define CTRL_RX_EN        0
`define CTRL_PARITY_EN    1
`define CTRL_DMA_RX       2
`define CTRL_DMA_TX       3
`define CTRL_SLEEP        4
`define ST1_W             6
`define ST1_RX_DATA_FULL_FLAG          0
`define ST1_OVERRUN       1
`define ST1_PARITY        2
`define ST1_LIN_RX_READY_FLAG         3
`define ST1_IDLE          4
`define ST1_FRAME         5
`define ST1_LIN_ACT       8
`define ST1_WAKE_ACT      9
`define ST1_DMA_ACT       10
`define ST2_W             5

// ----------------------------------------------------------------
// reset values and timing
// ----------------------------------------------------------------
`define CTRL_RESET        5'h01
`define BAUD_RESET        16'h00A2
`define LIN_TX_RESET      8'h00
`define SAMPLE_LAST       4'hF
`define SAMPLE_MID        4'h7
`define SAMPLE_FLAG       4'h9
`define DATA_LAST         4'h7
`define IDLE_LAST         4'h9

`endif

//--- design/lin_uart_pkg.sv
package lin_uart_pkg;
`include "lin_uart_params.svh"

  typedef enum logic [2:0] {
    RX_IDLE   = 3'b000,
    RX_START  = 3'b001,
    RX_DATA   = 3'b010,
    RX_PARITY = 3'b011,
    RX_STOP   = 3'b100
  } rx_state_t;

  typedef struct packed {
    logic [1:0]  sync;
    logic        prev;
    logic [15:0] tcnt;
    logic [3:0]  samp;
    logic [3:0]  bitn;
    logic [7:0]  shreg;
    logic        par;
    rx_state_t   state;
    logic        idle_arm;
    logic [3:0]  icnt;
    logic        done;
    logic [7:0]  data;
    logic        perr;
    logic        ferr;
    logic        idle;
  } rx_regs_t;

  typedef struct packed {
    logic [`CTRL_W-1:0] ctrl;
    logic [15:0]        baud;
    logic [7:0]         lin_tx;
    logic               tx_empty;
    logic [7:0]         rx_buf;
    logic [`ST1_W-1:0]  st1;
    logic [`ST2_W-1:0]  st2;
    logic [`ST1_W-1:0]  msk1;
    logic [`ST2_W-1:0]  msk2;
    logic [`ST2_W-1:0]  pend2;
    logic               lin_act;
    logic               wake_act;
    logic               dma_rx_req;
    logic               dma_tx_req;
    logic               ack;
    logic [31:0]        rdata;
    logic               irq;
  } top_regs_t;

endpackage

//--- design/lin_rx_sampler.sv
`timescale 1ns/100ps
`default_nettype none
`include "lin_uart_params.svh"
module lin_rx_sampler
  import lin_uart_pkg::*;
(
  // clock and reset
  input  wire logic        i_clk,
  input  wire logic        i_rst_n,
  // line and setup
  input  wire logic        i_rx_pin,
  input  wire logic        i_enable,
  input  wire logic        i_parity_en,
  input  wire logic [15:0] i_divisor,
  // results
  output logic             o_done,
  output logic [7:0]       o_data,
  output logic             o_par_err,
  output logic             o_frame_err,
  output logic             o_idle,
  output logic             o_line
);

  rx_regs_t r_q;
  rx_regs_t r_d;
  logic     tick;
  logic     bit_end;
  logic     mid;
  logic     line;

  always_comb
  begin
    r_d        = r_q;
    line       = r_q.sync[1];
    tick       = (r_q.tcnt == 16'h0000);
    mid        = tick && (r_q.samp == `SAMPLE_MID);
    bit_end    = tick && (r_q.samp == `SAMPLE_LAST);
    r_d.sync   = {r_q.sync[0], i_rx_pin};
    r_d.prev   = line;
    r_d.done   = 1'b0;
    r_d.perr   = 1'b0;
    r_d.ferr   = 1'b0;
    r_d.idle   = 1'b0;
    r_d.tcnt   = tick ? (i_divisor - 16'h0001) : (r_q.tcnt - 16'h0001);
    if (tick)
    begin
      r_d.samp = r_q.samp + 4'h1;
    end
    case (r_q.state)
      RX_IDLE:
      begin
        if (r_q.idle_arm && bit_end && line)
        begin
          if (r_q.icnt == `IDLE_LAST)
          begin
            r_d.idle     = 1'b1;
            r_d.idle_arm = 1'b0;
          end
          else
          begin
            r_d.icnt = r_q.icnt + 4'h1;
          end
        end
        if (i_enable && !line && r_q.prev)
        begin
          r_d.state    = RX_START;
          r_d.tcnt     = i_divisor - 16'h0001;
          r_d.samp     = 4'h0;
          r_d.par      = 1'b0;
          r_d.idle_arm = 1'b0;
        end
      end
      RX_START:
      begin
        // glitch shorter than half a bit is dropped
        if (mid && line)
        begin
          r_d.state = RX_IDLE;
        end
        else if (bit_end)
        begin
          r_d.state = RX_DATA;
          r_d.bitn  = 4'h0;
        end
      end
      RX_DATA:
      begin
        if (mid)
        begin
          r_d.shreg = {line, r_q.shreg[7:1]};
          r_d.par   = r_q.par ^ line;
        end
        if (bit_end)
        begin
          r_d.bitn = r_q.bitn + 4'h1;
          if (r_q.bitn == `DATA_LAST)
          begin
            r_d.state = i_parity_en ? RX_PARITY : RX_STOP;
          end
        end
      end
      RX_PARITY:
      begin
        if (mid)
        begin
          r_d.par = r_q.par ^ line;
        end
        if (bit_end)
        begin
          r_d.state = RX_STOP;
        end
      end
      RX_STOP:
      begin
        if (tick && (r_q.samp == `SAMPLE_FLAG))
        begin
          r_d.state = RX_IDLE;
          if (line)
          begin
            r_d.done     = 1'b1;
            r_d.data     = r_q.shreg;
            r_d.perr     = i_parity_en & r_q.par;
            r_d.idle_arm = 1'b1;
            r_d.icnt     = 4'h0;
          end
          else
          begin
            r_d.ferr = 1'b1;
          end
        end
      end
      default:
      begin
        r_d.state = RX_IDLE;
      end
    endcase
  end

  always_ff @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      r_q      <= '0;
      r_q.sync <= 2'h3;
      r_q.prev <= 1'b1;
    end
    else
    begin
      r_q <= r_d;
    end
  end

  assign o_done      = r_q.done;
  assign o_data      = r_q.data;
  assign o_par_err   = r_q.perr;
  assign o_frame_err = r_q.ferr;
  assign o_idle      = r_q.idle;
  assign o_line      = r_q.sync[1];

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (!i_rst_n);

  property p_done_at_tenth;
    o_done |-> $past(r_q.state == RX_STOP && tick && r_q.samp == 4'h9);
  endproperty
  a_done_at_tenth: assert property (p_done_at_tenth)
    else $error("character accepted away from tenth stop sample");

  property p_no_midframe_resync;
    (r_q.state == RX_DATA) && !tick |=> r_q.samp == $past(r_q.samp);
  endproperty
  a_no_midframe_resync: assert property (p_no_midframe_resync)
    else $error("sample phase moved inside data bits");

  property p_idle_after_stop;
    o_idle |-> $past(r_q.idle_arm && r_q.state == RX_IDLE);
  endproperty
  a_idle_after_stop: assert property (p_idle_after_stop)
    else $error("idle reported without a completed stop bit");

  c_char: cover property (o_done);
  c_idle: cover property (o_idle);

endmodule
`default_nettype wire

//--- dv/lin_node_model.sv
`timescale 1ns/100ps
`default_nettype none
module lin_node_model
#(
  parameter int BIT_CLKS = 64
)
(
  // clock
  input  wire logic i_clk,
  // serial line and stop-bit marker
  output logic      o_line,
  output logic      o_stop
);
  // -------------------------------------------------------------
  // line driver
  // -------------------------------------------------------------
  // line is driven high from the start, so an idle line reads high
  initial
  begin
    o_line = 1'b1;
    o_stop = 1'b0;
  end

  task automatic hold_bit(input logic lvl);
    begin
      o_line <= lvl;
      repeat (BIT_CLKS) @(posedge i_clk);
    end
  endtask

  task automatic drive_level(input logic lvl);
    begin
      o_line <= lvl;
      @(posedge i_clk);
    end
  endtask

  task automatic send_frame(input logic [7:0] d, input logic par_en,
                            input logic par_bad);
    int i;
    begin
      hold_bit(1'b0);
      for (i = 0; i < 8; i++)
        hold_bit(d[i]);
      if (par_en)
        hold_bit(^d ^ par_bad);
      o_stop <= 1'b1;
      hold_bit(1'b1);
      o_stop <= 1'b0;
    end
  endtask
endmodule
`default_nettype wire

//--- dv/lin_uart_rx_status_flags_bench.sv
`timescale 1ns/100ps
`default_nettype none
`include "lin_uart_params.svh"
module lin_uart_rx_status_flags_bench;
  localparam int BAUD_CLKS = 4;
  localparam int BIT_CLKS  = 16 * BAUD_CLKS;
  localparam logic [31:0] LIVE = 32'h0000072F;
  localparam int SEL_START = 0;
  localparam int SEL_DONE  = 1;
  localparam int SEL_TAKEN = 2;

  logic        clk;
  logic        rst_n;
  logic [2:0]  av_addr;
  logic        av_rd;
  logic        av_wr;
  logic [31:0] av_wdata;
  logic [31:0] av_rdata;
  logic        av_wait;
  logic        line;
  logic        stop;
  logic        f_start;
  logic        f_done;
  logic [4:0]  lin_ev;
  logic        tx_taken;
  logic [7:0]  lin_tx_data;
  logic        dma_rx;
  logic        dma_tx;
  logic        irq;
  int          n_mismatch;
  int          checks;

  initial
  begin
    clk = 1'b0;
    rst_n = 1'b0;
    av_addr = 3'h0;
    av_rd = 1'b0;
    av_wr = 1'b0;
    av_wdata = 32'h0;
    f_start = 1'b0;
    f_done = 1'b0;
    lin_ev = 5'h00;
    tx_taken = 1'b0;
    n_mismatch = 0;
    checks = 0;
  end
  always #20 clk = ~clk;

  lin_uart_rx_status_flags u_dut (
    .i_clk(clk), .i_rst_n(rst_n), .i_avs_address(av_addr),
    .i_avs_read(av_rd), .i_avs_write(av_wr), .i_avs_writedata(av_wdata),
    .o_avs_readdata(av_rdata), .o_avs_waitrequest(av_wait),
    .i_rx_pin(line), .i_lin_frame_start(f_start),
    .i_lin_frame_done(f_done), .i_lin_unreq(lin_ev[0]),
    .i_lin_bit_err(lin_ev[1]), .i_lin_overflow(lin_ev[2]),
    .i_lin_crc_err(lin_ev[3]), .i_lin_cks_err(lin_ev[4]),
    .i_tx_taken(tx_taken), .o_lin_tx_data(lin_tx_data),
    .o_dma_rx_req(dma_rx), .o_dma_tx_req(dma_tx), .o_irq(irq));

  lin_node_model #(.BIT_CLKS(BIT_CLKS)) u_node (
    .i_clk(clk), .o_line(line), .o_stop(stop));

  // -------------------------------------------------------------
  // shared tasks
  // -------------------------------------------------------------
  task automatic report_and_stop();
    begin
      $display("comparisons %0d mismatches %0d", checks, n_mismatch);
      if (n_mismatch == 0 && checks > 0)
        $display("ALL TESTS PASSED");
      else
        $display("TESTS FAILED");
      $finish;
    end
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    begin
      checks++;
      if (got !== exp)
      begin
        n_mismatch++;
        $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
    end
  endtask

  // waits for waitrequest sampled low, however long the slave takes;
  // read data are taken at that very edge
  task automatic bus_go(output logic [31:0] q);
    begin
      @(posedge clk);
      while (av_wait !== 1'b0)
        @(posedge clk);
      q = av_rdata;
      av_rd <= 1'b0;
      av_wr <= 1'b0;
      // idle edge so the strobe is never rewritten within one step
      @(posedge clk);
    end
  endtask

  task automatic bus_wr(input logic [2:0] a, input logic [31:0] d);
    logic [31:0] q;
    begin
      av_addr <= a;
      av_wdata <= d;
      av_wr <= 1'b1;
      bus_go(q);
    end
  endtask

  task automatic rd_chk(input logic [2:0] a, input logic [31:0] exp,
                        input logic [31:0] msk);
    logic [31:0] q;
    begin
      av_addr <= a;
      av_rd <= 1'b1;
      bus_go(q);
      chk(q & msk, exp);
    end
  endtask

  // one-cycle strobe on a frame engine or transmitter input
  task automatic pulse(input int sel);
    begin
      case (sel)
        SEL_START: f_start <= 1'b1;
        SEL_DONE:  f_done <= 1'b1;
        default:   tx_taken <= 1'b1;
      endcase
      @(posedge clk);
      f_start <= 1'b0;
      f_done <= 1'b0;
      tx_taken <= 1'b0;
      @(posedge clk);
    end
  endtask

  // irq quiet before the tenth stop sample, raised well before stop ends
  task automatic frame_irq(input logic [7:0] d, input logic pe,
                           input logic bad);
    begin
      fork
        u_node.send_frame(d, pe, bad);
        begin
          @(posedge stop);
          repeat (7 * BAUD_CLKS) @(posedge clk);
          chk({31'h0, irq}, 32'h0);
          repeat (6 * BAUD_CLKS) @(posedge clk);
          chk({31'h0, irq}, 32'h1);
        end
      join
    end
  endtask

  // -------------------------------------------------------------
  // scenarios
  // -------------------------------------------------------------
  task automatic t_reset_values();
    begin
      rd_chk(`IDX_CTRL, 32'h1, 32'hFFFFFFFF);
      rd_chk(`IDX_BAUD, 32'hA2, 32'hFFFFFFFF);
      rd_chk(`IDX_LIN_TX, 32'h0, 32'hFFFFFFFF);
      rd_chk(`IDX_MASK_ONE, 32'h0, 32'hFFFFFFFF);
      $display("test reset values done");
    end
  endtask

  task automatic t_lin_tx();
    begin
      bus_wr(`IDX_LIN_TX, 32'hA5);
      rd_chk(`IDX_LIN_TX, 32'hA5, 32'hFFFFFFFF);
      chk({24'h0, lin_tx_data}, 32'hA5);
      rd_chk(`IDX_STATUS_ONE, 32'h100, 32'h100);
      pulse(SEL_DONE);
      rd_chk(`IDX_STATUS_ONE, 32'h0, 32'h100);
      pulse(SEL_START);
      rd_chk(`IDX_STATUS_ONE, 32'h100, 32'h100);
      pulse(SEL_DONE);
      $display("test lin transmit and activity done");
    end
  endtask

  task automatic t_rx_timing();
    begin
      bus_wr(`IDX_BAUD, BAUD_CLKS);
      bus_wr(`IDX_MASK_ONE, 32'h1);
      frame_irq(8'h3C, 1'b0, 1'b0);
      rd_chk(`IDX_STATUS_ONE, 32'h9, LIVE);
      rd_chk(`IDX_STATUS_ONE, 32'h0, LIVE);
      rd_chk(`IDX_RX_DATA, 32'h3C, 32'hFFFFFFFF);
      chk({31'h0, irq}, 32'h0);
      repeat (11 * BIT_CLKS) @(posedge clk);
      rd_chk(`IDX_STATUS_ONE, 32'h10, 32'h10);
      bus_wr(`IDX_MASK_ONE, 32'h0);
      $display("test receive flag timing done");
    end
  endtask

  task automatic t_overrun_parity();
    begin
      bus_wr(`IDX_CTRL, 32'h3);
      bus_wr(`IDX_MASK_ONE, 32'h6);
      u_node.send_frame(8'h55, 1'b1, 1'b0);
      frame_irq(8'h81, 1'b1, 1'b1);
      rd_chk(`IDX_STATUS_ONE, 32'hF, LIVE);
      rd_chk(`IDX_RX_DATA, 32'h81, 32'hFF);
      bus_wr(`IDX_MASK_ONE, 32'h0);
      bus_wr(`IDX_CTRL, 32'h1);
      $display("test overrun and parity done");
    end
  endtask

  task automatic t_lin_flags();
    begin
      lin_ev <= 5'h1F;
      @(posedge clk);
      lin_ev <= 5'h00;
      rd_chk(`IDX_STATUS_TWO, 32'h0, 32'h1F);
      bus_wr(`IDX_MASK_TWO, 32'h1F);
      frame_irq(8'hC3, 1'b0, 1'b0);
      rd_chk(`IDX_STATUS_TWO, 32'h1F, 32'h1F);
      rd_chk(`IDX_STATUS_TWO, 32'h0, 32'h1F);
      bus_wr(`IDX_MASK_TWO, 32'h0);
      rd_chk(`IDX_STATUS_ONE, 32'h9, LIVE);
      rd_chk(`IDX_RX_DATA, 32'hC3, 32'hFF);
      $display("test lin error flags done");
    end
  endtask

  task automatic t_dma();
    begin
      bus_wr(`IDX_CTRL, 32'h5);
      u_node.send_frame(8'h5A, 1'b0, 1'b0);
      chk({31'h0, dma_rx}, 32'h1);
      rd_chk(`IDX_STATUS_ONE, 32'h400, LIVE);
      rd_chk(`IDX_RX_DATA, 32'h5A, 32'hFFFFFFFF);
      repeat (2) @(posedge clk);
      chk({31'h0, dma_rx}, 32'h0);
      bus_wr(`IDX_CTRL, 32'h9);
      pulse(SEL_TAKEN);
      chk({31'h0, dma_tx}, 32'h1);
      rd_chk(`IDX_STATUS_ONE, 32'h400, 32'h400);
      bus_wr(`IDX_CTRL, 32'h1);
      rd_chk(`IDX_STATUS_ONE, 32'h0, 32'h400);
      pulse(SEL_DONE);
      $display("test dma activity done");
    end
  endtask

  task automatic t_wakeup();
    begin
      bus_wr(`IDX_CTRL, 32'h10);
      u_node.drive_level(1'b0);
      repeat (4) @(posedge clk);
      rd_chk(`IDX_STATUS_ONE, 32'h200, 32'h200);
      u_node.drive_level(1'b1);
      repeat (4) @(posedge clk);
      rd_chk(`IDX_STATUS_ONE, 32'h0, 32'h200);
      bus_wr(`IDX_CTRL, 32'h1);
      $display("test wakeup activity done");
    end
  endtask

  // -------------------------------------------------------------
  // main sequence and watchdog
  // -------------------------------------------------------------
  initial
  begin
    repeat (6) @(posedge clk);
    rst_n <= 1'b1;
    repeat (3) @(posedge clk);
    t_reset_values();
    t_lin_tx();
    t_rx_timing();
    t_overrun_parity();
    t_lin_flags();
    t_dma();
    t_wakeup();
    report_and_stop();
  end

  // whole run is some four thousand two hundred cycles; allow generous margin
  initial
  begin
    repeat (40000) @(posedge clk);
    n_mismatch++;
    report_and_stop();
  end
endmodule
`default_nettype wire
